// ---- rcw_pkg.sv ----
// constants and types for the receiver control warm-up sequencer
// Contract
// [RULE1] eight receiver control lines driven from programmable patterns
// [RULE2] each setting holds a host pattern and a host duration
// [RULE3] each setting holds a battery-low poll enable
// [RULE4] reset puts all control lines at high impedance
// [RULE5] lines stay undriven until force-drive or run bit set
// [RULE6] after run bit, lines driven with settings until next reset
// [RULE7] warm-up is at most six steps: off plus enabled settings
// [RULE8] warm-up starts 160 ms before symbol data is needed
// [RULE9] first step holds off pattern for the idle time
// [RULE10] first warm-up setting applied after idle, only if enabled
// [RULE11] later settings follow in order; stop at first disabled
// [RULE12] after warm-up apply 1600 or 3200 search setting by state
// [RULE13] host keeps idle plus used durations within 160 ms
// [RULE14] over-budget warm-up starts shutdown when 160 ms window ends
// [RULE15] shutdown applies enabled shutdown settings then off
// [RULE16] poll battery-low just before leaving a polled setting; code polls only on timer or window exit in warm-up and shutdown
// [RULE17] run cleared while on runs shutdown; finish before new warm-up
// [RULE18] reset aborts sequence, clears timer, lines to high impedance
// [RULE19] steps timed in own clock cycles; switch when count reached
package rcw_pkg;
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned WINDOW_MS     = 160;
  localparam int unsigned WINDOW_CYCLES = CLK_HZ / 1000 * WINDOW_MS;
  localparam int unsigned DUR_W         = 24;
  localparam int unsigned NUM_SET       = 11;
  localparam int unsigned SET_W         = 4;
  localparam int unsigned ADDR_W        = 8;
  // setting indices
  localparam logic [3:0] SET_OFF   = 4'h0;
  localparam logic [3:0] SET_WU1   = 4'h1;
  localparam logic [3:0] SET_WU5   = 4'h5;
  localparam logic [3:0] SET_S1600 = 4'h6;
  localparam logic [3:0] SET_S3200 = 4'h7;
  localparam logic [3:0] SET_SD1   = 4'h8;
  localparam logic [3:0] SET_SD3   = 4'ha;
  // register map: index 0x00-0x0a pattern, 0x10-0x1a duration, 0x20-0x2a cfg
  localparam logic [7:0] ADR_PAT   = 8'h00;
  localparam logic [7:0] ADR_DUR   = 8'h10;
  localparam logic [7:0] ADR_CFG   = 8'h20;
  localparam logic [7:0] ADR_CTRL  = 8'h30;
  localparam logic [7:0] ADR_STAT  = 8'h31;
  localparam logic [7:0] ADR_IRQ_ST = 8'h32;
  localparam logic [7:0] ADR_IRQ_EN = 8'h33;
  localparam logic [7:0] ADR_IRQ_CLR = 8'h34;
  // field positions
  localparam int unsigned CFG_EN   = 0;
  localparam int unsigned CFG_POLL = 1;
  localparam int unsigned CTL_RUN  = 0;
  localparam int unsigned CTL_FRC  = 1;
  localparam int unsigned CTL_WARM = 2;
  localparam int unsigned CTL_R3200 = 3;
  // interrupt events
  localparam int unsigned IRQ_W       = 4;
  localparam int unsigned EV_SYNC     = 0;
  localparam int unsigned EV_OVERRUN  = 1;
  localparam int unsigned EV_OFF      = 2;
  localparam int unsigned EV_BATTERY_LOW_INPUT    = 3;
  typedef enum logic [2:0] {
    ST_IDLE, ST_WARM, ST_SYNC, ST_SHUT, ST_OFF
  } rcw_state_t;
endpackage

// ---- rcw_rx_model.sv ----
// receiver side model: pulled control lines and battery-low pin
`timescale 1ns/1ps
module rcw_rx_model (
  input  wire logic [7:0] lines_o,
  input  wire logic [7:0] lines_oe,
  input  wire logic       battery_low_input_level,
  output logic [7:0]      lines,
  output logic            battery_low_input
);
  // pull-downs define off
  // undriven bits read as the pull-down level, never the last driven value
  assign lines = lines_o & lines_oe;
  assign battery_low_input = battery_low_input_level;
endmodule

// ---- rcw_sequencer.sv ----
// receiver control warm-up and shutdown sequencer with register port
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module rcw_sequencer (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic        battery_low_input,
  input  wire logic        rx_ctrl_lines_i,
  output logic [7:0]       rx_ctrl_lines_o,
  output logic [7:0]       rx_ctrl_lines_oe,
  output logic             symbol_window_open,
  output logic             irq
);
  logic [7:0]                   pat_q [rcw_pkg::NUM_SET];
  logic [rcw_pkg::DUR_W-1:0]    dur_q [rcw_pkg::NUM_SET];
  logic [1:0]                   cfg_q [rcw_pkg::NUM_SET];
  logic                         run_q;
  logic                         frc_q;
  logic                         warm_req_q;
  logic                         r3200_q;
  logic                         driven_q;
  logic                         battery_low_input_q;
  logic                         battery_low_input_ev_q;
  logic                         battery_low_input_seen_q;
  logic [rcw_pkg::IRQ_W-1:0]    irq_st_q;
  logic [rcw_pkg::IRQ_W-1:0]    irq_en_q;
  logic [rcw_pkg::IRQ_W-1:0]    ev;
  rcw_pkg::rcw_state_t          state_q;
  logic [3:0]                   cur_q;
  logic [3:0]                   nxt;
  logic                         tmr_load;
  logic                         tmr_done;
  logic [rcw_pkg::DUR_W-1:0]    tmr_lim;
  logic [23:0]                  win_q;
  logic                         win_end;
  logic                         battery_low_input_s;
  logic                         leave;
  logic                         sel;
  logic [3:0]                   idx;

  rcw_sync2 u_battery_low_input (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     (battery_low_input),
    .dout    (battery_low_input_s)
  );

  rcw_timer #(.W(rcw_pkg::DUR_W)) u_tmr (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .load    (tmr_load),
    .limit   (tmr_lim),
    .done    (tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  assign sel = reg_addr[3:0] < 4'(rcw_pkg::NUM_SET);
  assign idx = reg_addr[3:0];

  // [RULE2] pattern and duration store
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < rcw_pkg::NUM_SET; i++) begin
        pat_q[i] <= 8'h00;
        dur_q[i] <= 24'h000001;
        cfg_q[i] <= 2'h0;
      end
    end else if (reg_wr && sel) begin
      if (reg_addr[7:4] == rcw_pkg::ADR_PAT[7:4]) begin
        pat_q[idx] <= reg_wdata[7:0];
      end else if (reg_addr[7:4] == rcw_pkg::ADR_DUR[7:4]) begin
        dur_q[idx] <= reg_wdata[rcw_pkg::DUR_W-1:0];
      end else if (reg_addr[7:4] == rcw_pkg::ADR_CFG[7:4]) begin
        // [RULE3] per-setting poll enable
        cfg_q[idx] <= reg_wdata[1:0];
      end
    end
  end

  // warm request is a self-clearing command bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      run_q      <= 1'b0;
      frc_q      <= 1'b0;
      warm_req_q <= 1'b0;
      r3200_q    <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == rcw_pkg::ADR_CTRL) begin
        run_q   <= reg_wdata[rcw_pkg::CTL_RUN];
        frc_q   <= reg_wdata[rcw_pkg::CTL_FRC];
        r3200_q <= reg_wdata[rcw_pkg::CTL_R3200];
      end
      if (reg_wr && reg_addr == rcw_pkg::ADR_CTRL && reg_wdata[rcw_pkg::CTL_WARM]) begin
        warm_req_q <= 1'b1;
      end else if (state_q == rcw_pkg::ST_IDLE || state_q == rcw_pkg::ST_OFF) begin
        if (run_q) begin
          warm_req_q <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  // [RULE11] next enabled warm-up setting, or search setting
  always_comb begin
    nxt = r3200_q ? rcw_pkg::SET_S3200 : rcw_pkg::SET_S1600;
    if (cur_q == rcw_pkg::SET_OFF) begin
      // [RULE10] first setting only if enabled
      if (cfg_q[rcw_pkg::SET_WU1][rcw_pkg::CFG_EN]) begin
        nxt = rcw_pkg::SET_WU1;
      end
    end else if (cur_q < rcw_pkg::SET_WU5 && cfg_q[cur_q + 4'h1][rcw_pkg::CFG_EN]) begin
      nxt = cur_q + 4'h1;
    end
  end

  // [RULE14] 160 ms window counter
  assign win_end = (state_q == rcw_pkg::ST_WARM) && (win_q == 24'(rcw_pkg::WINDOW_CYCLES - 1));
  // timer also reaches done in the other states, so leave is gated to warm-up and shutdown
  assign leave   = (state_q == rcw_pkg::ST_WARM || state_q == rcw_pkg::ST_SHUT) && (tmr_done || win_end);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      win_q <= 24'h000000;
    end else if (state_q != rcw_pkg::ST_WARM) begin
      win_q <= 24'h000000;
    end else begin
      win_q <= win_q + 24'h000001;
    end
  end

  logic       step_load;
  logic [3:0] step_set;

  // [RULE18] reset aborts the sequence
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= rcw_pkg::ST_IDLE;
      cur_q    <= rcw_pkg::SET_OFF;
    end else begin
      case (state_q)
        rcw_pkg::ST_IDLE, rcw_pkg::ST_OFF: begin
          cur_q <= rcw_pkg::SET_OFF;
          // [RULE8] warm-up request marks 160 ms before data
          if (run_q && warm_req_q) begin
            // [RULE9] idle step on off pattern
            state_q <= rcw_pkg::ST_WARM;
          end
        end
        rcw_pkg::ST_WARM: begin
          // [RULE17] run cleared aborts into shutdown
          if (!run_q || win_end) begin
            state_q <= rcw_pkg::ST_SHUT;
            cur_q   <= cfg_q[rcw_pkg::SET_SD1][rcw_pkg::CFG_EN] ? rcw_pkg::SET_SD1 : rcw_pkg::SET_OFF;
            if (!cfg_q[rcw_pkg::SET_SD1][rcw_pkg::CFG_EN]) begin
              state_q <= rcw_pkg::ST_OFF;
            end
          end else if (tmr_done) begin
            // [RULE7] at most six steps
            cur_q <= nxt;
            if (nxt == rcw_pkg::SET_S1600 || nxt == rcw_pkg::SET_S3200) begin
              // [RULE12] search setting
              state_q <= rcw_pkg::ST_SYNC;
            end
          end
        end
        rcw_pkg::ST_SYNC: begin
          if (!run_q) begin
            state_q <= cfg_q[rcw_pkg::SET_SD1][rcw_pkg::CFG_EN] ? rcw_pkg::ST_SHUT : rcw_pkg::ST_OFF;
            cur_q   <= cfg_q[rcw_pkg::SET_SD1][rcw_pkg::CFG_EN] ? rcw_pkg::SET_SD1 : rcw_pkg::SET_OFF;
          end else begin
            cur_q <= r3200_q ? rcw_pkg::SET_S3200 : rcw_pkg::SET_S1600;
          end
        end
        default: begin
          // [RULE15] shutdown settings then off
          if (tmr_done) begin
            if (cur_q < rcw_pkg::SET_SD3 && cfg_q[cur_q + 4'h1][rcw_pkg::CFG_EN]) begin
              cur_q <= cur_q + 4'h1;
            end else begin
              cur_q   <= rcw_pkg::SET_OFF;
              state_q <= rcw_pkg::ST_OFF;
            end
          end
        end
      endcase
    end
  end

  // step timer restart on every setting change
  logic [3:0] cur_prev_q;
  logic       first_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cur_prev_q <= rcw_pkg::SET_OFF;
      first_q    <= 1'b0;
    end else begin
      cur_prev_q <= cur_q;
      first_q    <= (state_q == rcw_pkg::ST_IDLE || state_q == rcw_pkg::ST_OFF) && run_q && warm_req_q;
    end
  end

  // [RULE19] reload on warm-up start and on each setting change
  assign step_load = (cur_q != cur_prev_q);
  assign step_set  = cur_q;
  assign tmr_load  = first_q || step_load;
  assign tmr_lim   = dur_q[step_set];

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  // [RULE16] battery poll before leaving a setting
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      battery_low_input_q      <= 1'b0;
      battery_low_input_ev_q   <= 1'b0;
      battery_low_input_seen_q <= 1'b0;
    end else begin
      battery_low_input_ev_q <= 1'b0;
      if (leave && cfg_q[cur_q][rcw_pkg::CFG_POLL]) begin
        // change only counts between two real reads
        battery_low_input_ev_q   <= battery_low_input_seen_q && (battery_low_input_s != battery_low_input_q);
        battery_low_input_q      <= battery_low_input_s;
        battery_low_input_seen_q <= 1'b1;
      end
    end
  end

  // [RULE5] drive once forced or running
  // [RULE6] driving holds until reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      driven_q <= 1'b0;
    end else if (run_q || frc_q) begin
      driven_q <= 1'b1;
    end
  end

  // [RULE4] undriven at reset
  // [RULE1] lines follow the active pattern
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_ctrl_lines_o    <= 8'h00;
      rx_ctrl_lines_oe   <= 8'h00;
      symbol_window_open <= 1'b0;
    end else begin
      rx_ctrl_lines_o    <= pat_q[cur_q];
      rx_ctrl_lines_oe   <= {8{driven_q}};
      symbol_window_open <= (state_q == rcw_pkg::ST_SYNC);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts and read port
  always_comb begin
    ev = '0;
    ev[rcw_pkg::EV_SYNC]    = (state_q == rcw_pkg::ST_WARM) && tmr_done && !win_end && run_q
                              && (nxt == rcw_pkg::SET_S1600 || nxt == rcw_pkg::SET_S3200);
    ev[rcw_pkg::EV_OVERRUN] = win_end;
    ev[rcw_pkg::EV_OFF]     = (state_q == rcw_pkg::ST_SHUT) && (cur_q != rcw_pkg::SET_OFF) && tmr_done
                              && !(cur_q < rcw_pkg::SET_SD3 && cfg_q[cur_q + 4'h1][rcw_pkg::CFG_EN]);
    ev[rcw_pkg::EV_BATTERY_LOW_INPUT]   = battery_low_input_ev_q;
  end

  // set wins over clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_q <= '0;
      irq_en_q <= '0;
      irq      <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == rcw_pkg::ADR_IRQ_CLR) begin
        irq_st_q <= (irq_st_q & ~reg_wdata[rcw_pkg::IRQ_W-1:0]) | ev;
      end else begin
        irq_st_q <= irq_st_q | ev;
      end
      if (reg_wr && reg_addr == rcw_pkg::ADR_IRQ_EN) begin
        irq_en_q <= reg_wdata[rcw_pkg::IRQ_W-1:0];
      end
      irq <= |((irq_st_q | ev) & irq_en_q);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      if (sel && reg_addr[7:4] == rcw_pkg::ADR_PAT[7:4]) begin
        reg_rdata <= {24'h000000, pat_q[idx]};
      end else if (sel && reg_addr[7:4] == rcw_pkg::ADR_DUR[7:4]) begin
        reg_rdata <= {8'h00, dur_q[idx]};
      end else if (sel && reg_addr[7:4] == rcw_pkg::ADR_CFG[7:4]) begin
        reg_rdata <= {30'h00000000, cfg_q[idx]};
      end else if (reg_addr == rcw_pkg::ADR_CTRL) begin
        reg_rdata <= {28'h0000000, r3200_q, warm_req_q, frc_q, run_q};
      end else if (reg_addr == rcw_pkg::ADR_STAT) begin
        reg_rdata <= {20'h00000, 3'(state_q), cur_q, battery_low_input_q, driven_q, rx_ctrl_lines_i, 2'h0};
      end else if (reg_addr == rcw_pkg::ADR_IRQ_ST) begin
        reg_rdata <= {28'h0000000, irq_st_q};
      end else if (reg_addr == rcw_pkg::ADR_IRQ_EN) begin
        reg_rdata <= {28'h0000000, irq_en_q};
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule

// ---- rcw_sequencer_chk.sv ----
// port assertions for the receiver control sequencer
`timescale 1ns/1ps
module rcw_sequencer_chk (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [7:0]  rx_ctrl_lines_oe,
  input wire logic        symbol_window_open,
  input wire logic        irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic drv_wr;
  logic mask_wr;
  assign drv_wr = reg_wr && reg_addr == rcw_pkg::ADR_CTRL && reg_wdata[1:0] != 2'h0;
  assign mask_wr = reg_wr && reg_addr == rcw_pkg::ADR_IRQ_EN && reg_wdata[3:0] == 4'h0;
  ////////////////////////////////////////////////////////////////////////////
  property p_rst_hiz; $rose(rst_n) |-> rx_ctrl_lines_oe == 8'h00 && !irq; endproperty
  a_rst_hiz: assert property (p_rst_hiz) else $error("lines driven after reset");
  // write at edge n: run bit at n, drive flag at n+1, enables seen from n+3
  property p_oe_cause; $rose(rx_ctrl_lines_oe[0]) |-> $past(drv_wr, 3); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("lines driven without cause");
  property p_oe_rise; drv_wr |-> ##3 rx_ctrl_lines_oe == 8'hff; endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("lines not driven on time");
  property p_oe_hold; rx_ctrl_lines_oe[0] |=> rx_ctrl_lines_oe[0]; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("drive dropped before reset");
  property p_oe_same; rx_ctrl_lines_oe == 8'h00 || rx_ctrl_lines_oe == 8'hff; endproperty
  a_oe_same: assert property (p_oe_same) else $error("line enables differ");
  property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_win_drv; symbol_window_open |-> rx_ctrl_lines_oe == 8'hff; endproperty
  a_win_drv: assert property (p_win_drv) else $error("search window while undriven");
  property p_irq_mask; mask_wr |-> ##2 !irq; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt still high");
  c_drive: cover property ($rose(rx_ctrl_lines_oe[0]));
  c_win: cover property ($rose(symbol_window_open));
  c_irq: cover property ($rose(irq));
endmodule
bind rcw_sequencer rcw_sequencer_chk u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_ctrl_lines_oe(rx_ctrl_lines_oe),
  .symbol_window_open(symbol_window_open), .irq(irq)
);

// ---- rcw_sequencer_tb.sv ----
// self-checking bench for the receiver control sequencer
`timescale 1ns/1ps
module rcw_sequencer_tb;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        battery_low_input_lvl = 1'b0;
  logic        spare_in = 1'b1;
  logic [31:0] reg_rdata;
  logic        battery_low_input;
  logic [7:0]  lines_o;
  logic [7:0]  lines_oe;
  logic [7:0]  lines;
  logic        win;
  logic        irq;
  logic [31:0] rv;
  int          n;
  int          failures = 0;
  int          checks_done = 0;
  initial forever #12.5 clk_sys = ~clk_sys;
  rcw_sequencer uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .battery_low_input(battery_low_input),
    .rx_ctrl_lines_i(spare_in), .rx_ctrl_lines_o(lines_o), .rx_ctrl_lines_oe(lines_oe),
    .symbol_window_open(win), .irq(irq)
  );
  rcw_rx_model u_rx (
    .lines_o(lines_o), .lines_oe(lines_oe), .battery_low_input_level(battery_low_input_lvl), .lines(lines),
    .battery_low_input(battery_low_input)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_cnt(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      failures++;
      $display("CHECK FAILED %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // waits for a line pattern; a bound that runs out ends the run
  task automatic wait_pat(input logic [7:0] p, output int c);
    c = 0;
    #1;
    while (lines !== p) begin
      @(posedge clk_sys);
      #1 c++;
      if (c > 300) begin
        failures++;
        $display("CHECK FAILED %0t: pattern %h never seen", $time, p);
        give_verdict();
      end
    end
  endtask
  task automatic hold(input logic [7:0] p, output int c);
    c = 0;
    while (lines === p && c < 300) begin
      @(posedge clk_sys);
      #1 c++;
    end
    if (c >= 300) begin
      failures++;
      $display("CHECK FAILED %0t: pattern %h never left", $time, p);
      give_verdict();
    end
  endtask
  function automatic logic [31:0] cfgv(input int i);
    return {30'h0, i == 1 || i == 2, !(i == 3 || i == 9)};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 cmp32(lines_oe, 32'h0);
    cmp32(lines, 32'h0);
    // patterns 0x20+i, durations 4+2i; setting 3 and 9 disabled
    // idle plus used warm-up steps stay far inside the window
    for (int i = 0; i < 11; i++) begin
      wr(rcw_pkg::ADR_PAT + 8'(i), 32'h20 + 32'(i));
      wr(rcw_pkg::ADR_DUR + 8'(i), 32'(4 + 2 * i));
      wr(rcw_pkg::ADR_CFG + 8'(i), cfgv(i));
      rd(rcw_pkg::ADR_PAT + 8'(i), rv);
      cmp32(rv, 32'h20 + 32'(i));
      rd(rcw_pkg::ADR_DUR + 8'(i), rv);
      cmp32(rv, 32'(4 + 2 * i));
      rd(rcw_pkg::ADR_CFG + 8'(i), rv);
      cmp32(rv, cfgv(i));
    end
    rd(8'h40, rv);
    cmp32(rv, 32'h0);
    cmp32(lines_oe, 32'h0);
    wr(rcw_pkg::ADR_CTRL, 32'h2);
    repeat (3) @(posedge clk_sys);
    #1 cmp32(lines_oe, 32'hff);
    cmp32(lines, 32'h20);
    // status: driven flag and the high spare input, still idle on off
    rd(rcw_pkg::ADR_STAT, rv);
    cmp32(rv, 32'hc);
    wr(rcw_pkg::ADR_CTRL, 32'h5);
    wait_pat(8'h21, n);
    cmp_cnt(n, 4, 8);
    hold(8'h21, n);
    cmp_cnt(n, 6, 6);
    cmp32(lines, 32'h22);
    // battery level changes between the two polled settings
    battery_low_input_lvl <= 1'b1;
    hold(8'h22, n);
    cmp_cnt(n, 8, 8);
    cmp32(lines, 32'h26);
    repeat (2) @(posedge clk_sys);
    #1 cmp32(win, 32'h1);
    rd(rcw_pkg::ADR_IRQ_ST, rv);
    cmp32(rv, 32'h9);
    cmp32(irq, 32'h0);
    wr(rcw_pkg::ADR_IRQ_EN, 32'h8);
    repeat (2) @(posedge clk_sys);
    #1 cmp32(irq, 32'h1);
    wr(rcw_pkg::ADR_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk_sys);
    #1 cmp32(irq, 32'h0);
    wr(rcw_pkg::ADR_IRQ_EN, 32'h8);
    wr(rcw_pkg::ADR_IRQ_CLR, 32'h8);
    repeat (2) @(posedge clk_sys);
    #1 cmp32(irq, 32'h0);
    // run cleared, then set again while the shutdown step is running
    wr(rcw_pkg::ADR_CTRL, 32'h0);
    wait_pat(8'h28, n);
    cmp_cnt(n, 0, 4);
    fork
      hold(8'h28, n);
      wr(rcw_pkg::ADR_CTRL, 32'hd);
    join
    cmp_cnt(n, 20, 20);
    cmp32(lines, 32'h20);
    cmp32(lines_oe, 32'hff);
    rd(rcw_pkg::ADR_IRQ_ST, rv);
    cmp32(rv & 32'h4, 32'h4);
    wait_pat(8'h21, n);
    cmp_cnt(n, 3, 8);
    wait_pat(8'h27, n);
    cmp_cnt(n, 14, 14);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    #1 cmp32(lines_oe, 32'h0);
    cmp32(lines, 32'h0);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    give_verdict();
  end
endmodule

// ---- rcw_sync2.sv ----
// two-flip-flop synchroniser for a pin input
`timescale 1ns/1ps
module rcw_sync2 (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// ---- rcw_timer.sv ----
// step timer counting clock cycles against a programmed duration
`timescale 1ns/1ps
module rcw_timer #(
  parameter int unsigned W = 24
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] limit,
  output logic              done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] lim_q;
  // [RULE19] count to limit
  assign done = !load && (cnt_q + W'(1) >= lim_q);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      lim_q <= '0;
    end else if (load) begin
      // load comes one cycle into the step, so that cycle is counted
      cnt_q <= W'(1);
      lim_q <= limit;
    end else if (!done) begin
      cnt_q <= cnt_q + W'(1);
    end
  end
endmodule
